// ===== dv/event_source_model.sv
// Random retry and force-ack sources of the memory controller and home logic
`timescale 1ns/100ps
`default_nettype none
module event_source_model (
   input  wire logic  clk_in,
   input  wire logic  enable_in,
   input  wire logic  ras_mode_in,
   input  wire logic  stray_in,
   output logic [2:0] retry_out = 3'h0,
   output logic [2:0] force_ack_out = 3'h0
);
   // Retries only in reliability mode, unless a stray burst is commanded
   always @(posedge clk_in) begin
      retry_out     <= (enable_in && (ras_mode_in || stray_in)) ? 3'($urandom) : 3'h0;
      force_ack_out <= enable_in ? 3'($urandom) : 3'h0;
   end
endmodule
`default_nettype wire

// ===== dv/uncore_home_memory_event_select_bench.sv
// Self-checking bench of the home/memory event selector
`timescale 1ns/100ps
`default_nettype none
module uncore_home_memory_event_select_bench;
   import uncore_event_pkg::*;
   logic        clk = 0, rst_n = 0, clr = 0, ras = 1, en = 0, stray = 0;
   logic [7:0]  ev = 8'h0, mask = 8'h0;
   logic        req_v = 0, sleep_v = 0, wake_v = 0, done_v = 0;
   mem_req_t    req = '0;
   logic [1:0]  sleep_s = 2'h0, wake_s = 2'h0, done_s = 2'h0;
   logic [5:0]  cause = 6'h0;
   logic [2:0]  retry, ack;
   logic        ready, sched_v, prio_v;
   logic [1:0]  sched_s, sched_c, prio_s, prio_c;
   logic [31:0] sched_a, a;
   logic [47:0] count, want;
   int          bad_count = 0, n_compared = 0;
   // Rows of {reliability mode, event number, unit mask}
   logic [16:0] tbl [12] = '{17'h13201, 17'h13202, 17'h13204, 17'h13207, 17'h13205,
      17'h03207, 17'h13301, 17'h13302, 17'h13304, 17'h13307, 17'h13306, 17'h13507};

   uncore_home_memory_event_select u_dut (
      .sys_clk_in(clk), .rst_n_in(rst_n), .event_num_in(ev), .unit_mask_in(mask),
      .count_clear_in(clr), .ras_mode_in(ras), .retry_in(retry), .force_ack_in(ack),
      .req_valid_in(req_v), .req_in(req), .sleep_valid_in(sleep_v), .sleep_slot_in(sleep_s),
      .sleep_cause_in(cause), .wake_valid_in(wake_v), .wake_slot_in(wake_s),
      .done_valid_in(done_v), .done_slot_in(done_s), .req_ready_out(ready),
      .sched_valid_out(sched_v), .sched_slot_out(sched_s), .sched_addr_out(sched_a),
      .sched_chan_out(sched_c), .prio_update_valid_out(prio_v),
      .prio_update_slot_out(prio_s), .prio_update_chan_out(prio_c), .count_out(count));
   event_source_model u_src (.clk_in(clk), .enable_in(en), .ras_mode_in(ras),
      .stray_in(stray), .retry_out(retry), .force_ack_out(ack));

   initial forever #5 clk = ~clk;

   task automatic check(input logic [47:0] seen, input logic [47:0] exp_v);
      n_compared++;
      if (seen !== exp_v) begin
         bad_count++;
         $display("unexpected at %0t: saw %0h, wanted %0h", $time, seen, exp_v);
      end
   endtask
   task automatic finish_test();
      $display("compared %0d, mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   function automatic int gain(input logic [16:0] row, input logic [2:0] rt, input logic [2:0] fa);
      case (row[15:8])
         8'h32: return row[16] ? $countones(rt & row[2:0]) : 0;
         8'h33: return $countones(fa & row[2:0]);
         default: return 0;
      endcase
   endfunction
   task automatic send(input logic [31:0] ad, input logic [1:0] ch, input logic iso);
      @(posedge clk);
      req_v <= 1'b1;
      req   <= '{addr: ad, chan: ch, isochronous_class: iso};
      @(posedge clk);
      req_v <= 1'b0;
   endtask
   task automatic wait_sched(input logic [31:0] ad, input logic [1:0] ch, input logic [1:0] s);
      repeat (8) begin
         @(posedge clk);
         #1;
         if (sched_v === 1'b1) break;
      end
      check(sched_v, 1'b1);
      check({sched_s, sched_c, sched_a}, {s, ch, ad});
   endtask
   task automatic release_slot(input logic [1:0] s);
      @(posedge clk);
      done_v <= 1'b1;
      done_s <= s;
      @(posedge clk);
      done_v <= 1'b0;
   endtask

   initial begin
      repeat (3000) @(posedge clk);
      bad_count++;
      finish_test();
   end

   initial begin
      void'($urandom(32'h2b19));
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      repeat (2) @(posedge clk);
      foreach (tbl[i]) begin
         {ras, ev, mask} <= tbl[i];
         stray <= ~tbl[i][16];
         clr   <= 1'b1;
         want = '0;
         @(posedge clk);
         clr <= 1'b0;
         en  <= 1'b1;
         repeat (20) begin
            @(posedge clk);
            #1;
            want += 48'(gain(tbl[i], retry, ack));
         end
         en <= 1'b0;
         repeat (3) @(posedge clk);
         #1;
         check(count, want);
         @(posedge clk);
      end
      ev   <= 8'h31;
      mask <= 8'h07;
      clr  <= 1'b1;
      @(posedge clk);
      clr <= 1'b0;
      for (int c = 0; c < 3; c++) begin
         a = $urandom;
         send(a, 2'(c), 1'b0);
         wait_sched(a, 2'(c), 2'(c));
         send(a, 2'(c), 1'b1);
         #1;
         check({prio_v, prio_s, prio_c}, {1'b1, 2'(c), 2'(c)});
         check(count, 48'(c + 1));
         check(ready, 1'b1);
      end
      // Fill the last slot: the table is full and an isochronous match is refused
      send($urandom, 2'h0, 1'b0);
      #1;
      check(ready, 1'b0);
      send(a, 2'h2, 1'b1);
      #1;
      check(prio_v, 1'b0);
      check(count, 48'h3);
      for (int c = 0; c < 4; c++) release_slot(2'(c));
      ev <= 8'h34;
      for (int k = 0; k < 6; k++) begin
         @(posedge clk);
         mask  <= 8'(1 << k);
         cause <= 6'(1 << k);
         clr   <= 1'b1;
         @(posedge clk);
         clr <= 1'b0;
         a = $urandom;
         send(a, 2'(k % 3), 1'b0);
         sleep_v <= 1'b1;
         sleep_s <= 2'h0;
         @(posedge clk);
         sleep_v <= 1'b0;
         repeat (6) begin
            @(posedge clk);
            #1;
            check(sched_v, 1'b0);
         end
         check(count, 48'h1);
         @(posedge clk);
         wake_v <= 1'b1;
         wake_s <= 2'h0;
         @(posedge clk);
         wake_v <= 1'b0;
         wait_sched(a, 2'(k % 3), 2'h0);
         release_slot(2'h0);
      end
      finish_test();
   end
endmodule
`default_nettype wire

// ===== dv/uncore_home_memory_event_select_monitor.sv
// Port-level checks of the home/memory event selector
`timescale 1ns/100ps
`default_nettype none
module uncore_home_memory_event_select_monitor #(
   parameter int COUNT_W = 48,
   parameter int SLOT_W  = 2
) (
   input wire logic                   sys_clk_in,
   input wire logic                   rst_n_in,
   input wire logic [7:0]             event_num_in,
   input wire logic [7:0]             unit_mask_in,
   input wire logic                   count_clear_in,
   input wire logic                   ras_mode_in,
   input wire logic [2:0]             retry_in,
   input wire logic [2:0]             force_ack_in,
   input wire logic                   req_valid_in,
   input wire uncore_event_pkg::mem_req_t req_in,
   input wire logic                   sleep_valid_in,
   input wire logic [SLOT_W-1:0]      sleep_slot_in,
   input wire logic                   req_ready_out,
   input wire logic                   sched_valid_out,
   input wire logic [SLOT_W-1:0]      sched_slot_out,
   input wire logic                   prio_update_valid_out,
   input wire logic [COUNT_W-1:0]     count_out
);
   import uncore_event_pkg::*;
   logic [2:0] retry_sel, ack_sel;
   logic       iso_take;
   assign retry_sel = retry_in & unit_mask_in[2:0];
   assign ack_sel   = force_ack_in & unit_mask_in[2:0];
   assign iso_take  = req_valid_in & req_ready_out & req_in.isochronous_class;
   default clocking @(posedge sys_clk_in); endclocking
   default disable iff (!rst_n_in);
   // ==========================================================
   // Counting
   chk_retry_select: assert property (
      event_num_in == 8'h32 && ras_mode_in && !count_clear_in
      |=> count_out == $past(count_out) + $countones($past(retry_sel))) else $error("retry count");
   chk_retry_gate: assert property (
      event_num_in == 8'h32 && !ras_mode_in && !count_clear_in |=> $stable(count_out))
      else $error("retry counted outside reliability mode");
   chk_ack_select: assert property (
      event_num_in == 8'h33 && !count_clear_in
      |=> count_out == $past(count_out) + $countones($past(ack_sel))) else $error("ack count");
   chk_prio_count: assert property (
      event_num_in == 8'h31 && unit_mask_in == 8'h07 && !count_clear_in
      |=> count_out == $past(count_out) + (prio_update_valid_out ? 1 : 0))
      else $error("priority update count");
   chk_clear_zero: assert property (count_clear_in |=> count_out == '0)
      else $error("count not cleared");
   // ==========================================================
   // Request table
   chk_prio_cause: assert property (
      prio_update_valid_out |-> $past(iso_take)) else $error("priority update without cause");
   chk_sleep_block: assert property (
      sleep_valid_in |=> !(sched_valid_out && sched_slot_out == $past(sleep_slot_in)))
      else $error("sleeping slot scheduled");
   chk_reset_quiet: assert property (disable iff (1'b0) !rst_n_in
      |=> !sched_valid_out && !prio_update_valid_out && !req_ready_out && count_out == '0)
      else $error("outputs active in reset");
endmodule

bind uncore_home_memory_event_select uncore_home_memory_event_select_monitor #(
   .COUNT_W(COUNT_W), .SLOT_W(SLOT_W)
) u_monitor (
   .sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .event_num_in(event_num_in),
   .unit_mask_in(unit_mask_in), .count_clear_in(count_clear_in), .ras_mode_in(ras_mode_in),
   .retry_in(retry_in), .force_ack_in(force_ack_in), .req_valid_in(req_valid_in),
   .req_in(req_in), .sleep_valid_in(sleep_valid_in), .sleep_slot_in(sleep_slot_in),
   .req_ready_out(req_ready_out), .sched_valid_out(sched_valid_out),
   .sched_slot_out(sched_slot_out), .prio_update_valid_out(prio_update_valid_out),
   .count_out(count_out)
);
`default_nettype wire

// ===== hw/event_match_unit.sv
// Selects the occurrences named by event number and unit mask and counts them
`timescale 1ns/100ps
`default_nettype none
`include "uncore_event_regs.svh"

module event_match_unit (
   input  wire logic [`EVT_NUM_W-1:0]         event_num_in,
   input  wire logic [`EVT_NUM_W-1:0]         unit_mask_in,
   input  wire uncore_event_pkg::event_vec_t  events_in,
   output logic [`INCR_W-1:0]                 incr_out
);
   import uncore_event_pkg::*;

   logic [`NUM_SLEEP_CAUSE-1:0] group_bits;

   function automatic logic [`INCR_W-1:0] popcount(input logic [`NUM_SLEEP_CAUSE-1:0] v);
      logic [`INCR_W-1:0] n;
      n = '0;
      for (int i = 0; i < `NUM_SLEEP_CAUSE; i++) begin
         n = n + `INCR_W'(v[i]);
      end
      return n;
   endfunction

   // ==========================================================
   // Event group select
   always_comb begin
      case (event_num_in)
         `EVT_PRIO_UPDATE: group_bits = {3'h0, events_in.prio_update}; // [RULE_01]
         `EVT_DRAM_RETRY:  group_bits = {3'h0, events_in.retry};       // [RULE_03] [RULE_04]
         `EVT_FORCE_ACK:   group_bits = {3'h0, events_in.force_ack};   // [RULE_06] [RULE_07]
         `EVT_REQ_SLEEP:   group_bits = events_in.sleep;              // [RULE_08] [RULE_09]
         default:          group_bits = '0;
      endcase
   end

   // Each selected occurrence adds one
   always_comb begin
      incr_out = popcount(group_bits & unit_mask_in[`NUM_SLEEP_CAUSE-1:0]); // [RULE_11]
   end

endmodule
`default_nettype wire

// ===== hw/uncore_event_pkg.sv
// Types shared by the home/memory event selector
`default_nettype none
`include "uncore_event_regs.svh"

package uncore_event_pkg;

   // ==========================================================
   // Occurrences seen in one cycle, one bit per qualifier
   typedef struct packed {
      logic [`NUM_SLEEP_CAUSE-1:0] sleep;
      logic [`NUM_DEST-1:0]        force_ack;
      logic [`NUM_CHAN-1:0]        retry;
      logic [`NUM_CHAN-1:0]        prio_update;
   } event_vec_t;

   // ==========================================================
   // Request arriving at the home logic
   typedef struct packed {
      logic [`ADDR_WIDTH-1:0] addr;
      logic [`CHAN_W-1:0]     chan;
      logic                   isochronous_class;
   } mem_req_t;

   // ==========================================================
   // Home logic request slot
   typedef struct packed {
      logic                   valid;
      logic                   issued;
      logic                   asleep;
      logic [`CHAN_W-1:0]     chan;
      logic [`ADDR_WIDTH-1:0] addr;
   } slot_t;

endpackage
`default_nettype wire

// ===== hw/uncore_event_regs.svh
// Event numbers, unit-mask bit positions and widths of the home/memory event selector
`ifndef UNCORE_EVENT_REGS_SVH
`define UNCORE_EVENT_REGS_SVH

// ==========================================================
// Event numbers
`define EVT_NUM_W          8
`define EVT_PRIO_UPDATE    8'h31
`define EVT_DRAM_RETRY     8'h32
`define EVT_FORCE_ACK      8'h33
`define EVT_REQ_SLEEP      8'h34

// ==========================================================
// Unit-mask bit positions
`define UMASK_CH0          0
`define UMASK_CH1          1
`define UMASK_CH2          2
`define UMASK_IO_HUB       0
`define UMASK_REMOTE       1
`define UMASK_LOCAL        2
`define UMASK_IO_HUB_ORDER 0
`define UMASK_REM_ORDER    1
`define UMASK_LOC_ORDER    2
`define UMASK_IO_HUB_CONFL 3
`define UMASK_REM_CONFLICT 4
`define UMASK_LOC_CONFLICT 5

// ==========================================================
// Widths
`define NUM_CHAN           3
`define CHAN_W             2
`define NUM_DEST           3
`define NUM_SLEEP_CAUSE    6
`define ADDR_WIDTH         32
`define INCR_W             3

`endif

// ===== hw/uncore_home_memory_event_select.sv
// Home logic request table with event selection and counting
// Operation
// (RULE_01) Event 31H with mask 07H counts every priority update sent on any channel.
// (RULE_02) An isochronous request that matches an issued normal request sends a priority update; none is sent while req_ready_out is low (table full).
// (RULE_03) Event 32H with masks 01H, 02H, 04H counts retries on channel 0, 1 and 2.
// (RULE_04) Event 32H with mask 07H counts retries on any channel.
// (RULE_05) Retries count only while the memory controller is in reliability mode.
// (RULE_06) Event 33H with masks 01H, 02H, 04H counts force-ack conflicts to I/O hub, remote, local.
// (RULE_07) Event 33H with mask 07H counts every force-ack conflict message.
// (RULE_08) Event 34H with masks 01H, 02H, 04H counts ordering sleeps from I/O hub, remote, local.
// (RULE_09) Event 34H with masks 08H, 10H, 20H counts address-conflict sleeps from the same sources.
// (RULE_10) A sleeping request is never scheduled to the memory controller queue.
// (RULE_11) With several mask bits set, an occurrence matching any selected bit counts.
`timescale 1ns/100ps
`default_nettype none
`include "uncore_event_regs.svh"

module uncore_home_memory_event_select #(
   parameter int NUM_SLOTS = 4,
   parameter int COUNT_W   = 48,
   parameter int SLOT_W    = $clog2(NUM_SLOTS)
) (
   input  wire logic                            sys_clk_in,
   input  wire logic                            rst_n_in,
   input  wire logic [`EVT_NUM_W-1:0]           event_num_in,
   input  wire logic [`EVT_NUM_W-1:0]           unit_mask_in,
   input  wire logic                            count_clear_in,
   input  wire logic                            ras_mode_in,
   input  wire logic [`NUM_CHAN-1:0]            retry_in,
   input  wire logic [`NUM_DEST-1:0]            force_ack_in,
   input  wire logic                            req_valid_in,
   input  wire uncore_event_pkg::mem_req_t      req_in,
   input  wire logic                            sleep_valid_in,
   input  wire logic [SLOT_W-1:0]               sleep_slot_in,
   input  wire logic [`NUM_SLEEP_CAUSE-1:0]     sleep_cause_in,
   input  wire logic                            wake_valid_in,
   input  wire logic [SLOT_W-1:0]               wake_slot_in,
   input  wire logic                            done_valid_in,
   input  wire logic [SLOT_W-1:0]               done_slot_in,
   output logic                                 req_ready_out,
   output logic                                 sched_valid_out,
   output logic [SLOT_W-1:0]                    sched_slot_out,
   output logic [`ADDR_WIDTH-1:0]               sched_addr_out,
   output logic [`CHAN_W-1:0]                   sched_chan_out,
   output logic                                 prio_update_valid_out,
   output logic [SLOT_W-1:0]                    prio_update_slot_out,
   output logic [`CHAN_W-1:0]                   prio_update_chan_out,
   output logic [COUNT_W-1:0]                   count_out
);
   import uncore_event_pkg::*;

   // ==========================================================
   // Declarations
   slot_t                        slots [NUM_SLOTS];
   slot_t                        next_slots [NUM_SLOTS];
   logic                         next_req_ready;
   logic                         next_sched_valid;
   logic [SLOT_W-1:0]            next_sched_slot;
   logic [`ADDR_WIDTH-1:0]       next_sched_addr;
   logic [`CHAN_W-1:0]           next_sched_chan;
   logic                         next_prio_valid;
   logic [SLOT_W-1:0]            next_prio_slot;
   logic [`CHAN_W-1:0]           next_prio_chan;
   logic                         sched_found;
   logic                         match_found;
   logic [SLOT_W-1:0]            match_slot;
   logic                         free_found;
   logic [SLOT_W-1:0]            free_slot;
   logic                         sleep_taken;
   event_vec_t                   events;
   logic [`INCR_W-1:0]           incr;
   logic [COUNT_W-1:0]           count;
   logic [COUNT_W-1:0]           next_count;

   function automatic logic [`NUM_CHAN-1:0] chan_onehot(input logic [`CHAN_W-1:0] ch);
      logic [`NUM_CHAN-1:0] v;
      v = '0;
      for (int i = 0; i < `NUM_CHAN; i++) begin
         if (ch == `CHAN_W'(i)) begin
            v[i] = 1'b1;
         end
      end
      return v;
   endfunction

   // ==========================================================
   // Slot lookup
   always_comb begin
      match_found = 1'b0;
      match_slot  = '0;
      free_found  = 1'b0;
      free_slot   = '0;
      for (int i = 0; i < NUM_SLOTS; i++) begin
         if (!match_found && slots[i].valid && slots[i].issued &&
             slots[i].addr == req_in.addr) begin
            match_found = 1'b1;
            match_slot  = SLOT_W'(i);
         end
         if (!free_found && !slots[i].valid) begin
            free_found = 1'b1;
            free_slot  = SLOT_W'(i);
         end
      end
   end

   // ==========================================================
   // Slot table next state
   always_comb begin
      for (int i = 0; i < NUM_SLOTS; i++) begin
         next_slots[i] = slots[i];
      end
      next_sched_valid = 1'b0;
      next_sched_slot  = '0;
      next_sched_addr  = '0;
      next_sched_chan  = '0;
      next_prio_valid  = 1'b0;
      next_prio_slot   = '0;
      next_prio_chan   = '0;
      sched_found      = 1'b0;
      sleep_taken      = 1'b0;

      // Lowest-index ready slot goes to the queue; a slot put to sleep now is skipped
      for (int i = 0; i < NUM_SLOTS; i++) begin
         if (!sched_found && slots[i].valid && !slots[i].issued &&
             !slots[i].asleep &&                                     // [RULE_10]
             !(sleep_valid_in && sleep_slot_in == SLOT_W'(i))) begin // [RULE_10]
            sched_found          = 1'b1;
            next_sched_valid     = 1'b1;
            next_sched_slot      = SLOT_W'(i);
            next_sched_addr      = slots[i].addr;
            next_sched_chan      = slots[i].chan;
            next_slots[i].issued = 1'b1;
         end
      end

      if (wake_valid_in) begin
         next_slots[wake_slot_in].asleep = 1'b0;
      end

      // Sleep of an awake slot wins over a wake of it in the same cycle; an asleep slot is woken
      if (sleep_valid_in && slots[sleep_slot_in].valid &&
          !slots[sleep_slot_in].issued && !slots[sleep_slot_in].asleep) begin
         next_slots[sleep_slot_in].asleep = 1'b1;                    // [RULE_10]
         sleep_taken                      = 1'b1;
      end

      if (done_valid_in) begin
         next_slots[done_slot_in] = '0;
      end

      if (req_valid_in && req_ready_out) begin
         if (req_in.isochronous_class && match_found) begin
            next_prio_valid = 1'b1;                                  // [RULE_02]
            next_prio_slot  = match_slot;                            // [RULE_02]
            next_prio_chan  = slots[match_slot].chan;                // [RULE_02]
         end else if (free_found) begin
            next_slots[free_slot].valid  = 1'b1;
            next_slots[free_slot].issued = 1'b0;
            next_slots[free_slot].asleep = 1'b0;
            next_slots[free_slot].chan   = req_in.chan;
            next_slots[free_slot].addr   = req_in.addr;
         end
      end

      next_req_ready = 1'b0;
      for (int i = 0; i < NUM_SLOTS; i++) begin
         if (!next_slots[i].valid) begin
            next_req_ready = 1'b1;
         end
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         for (int i = 0; i < NUM_SLOTS; i++) begin
            slots[i] <= '0;
         end
         req_ready_out         <= 1'b0;
         sched_valid_out       <= 1'b0;
         sched_slot_out        <= '0;
         sched_addr_out        <= '0;
         sched_chan_out        <= '0;
         prio_update_valid_out <= 1'b0;
         prio_update_slot_out  <= '0;
         prio_update_chan_out  <= '0;
      end else begin
         for (int i = 0; i < NUM_SLOTS; i++) begin
            slots[i] <= next_slots[i];
         end
         req_ready_out         <= next_req_ready;
         sched_valid_out       <= next_sched_valid;
         sched_slot_out        <= next_sched_slot;
         sched_addr_out        <= next_sched_addr;
         sched_chan_out        <= next_sched_chan;
         prio_update_valid_out <= next_prio_valid;
         prio_update_slot_out  <= next_prio_slot;
         prio_update_chan_out  <= next_prio_chan;
      end
   end

   // ==========================================================
   // Occurrences of this cycle
   always_comb begin
      events.prio_update = next_prio_valid ? chan_onehot(next_prio_chan) : '0; // [RULE_01]
      events.retry       = retry_in & {`NUM_CHAN{ras_mode_in}};                // [RULE_05]
      events.force_ack   = force_ack_in;                                       // [RULE_06]
      events.sleep       = sleep_cause_in & {`NUM_SLEEP_CAUSE{sleep_taken}};   // [RULE_08]
   end

   event_match_unit u_match (
      .event_num_in (event_num_in),
      .unit_mask_in (unit_mask_in),
      .events_in    (events),
      .incr_out     (incr)
   );

   // ==========================================================
   // Event counter
   always_comb begin
      if (count_clear_in) begin
         next_count = '0;
      end else begin
         next_count = count + COUNT_W'(incr); // [RULE_04] [RULE_07] [RULE_09]
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         count <= '0;
      end else begin
         count <= next_count;
      end
   end

   assign count_out = count;

endmodule
`default_nettype wire
